// File: src/crs_pkg.sv
// Purpose: Shared constants and types for the CAN remote-frame scheduler block
// Assumes: One 40 MHz clock; byte offsets on the plain register port
// Notes:   Session modes are software encodings held in the control register

package crs_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] CRS_OFF_CTRL     = 8'h00;
  localparam logic [7:0] CRS_OFF_ID       = 8'h04;
  localparam logic [7:0] CRS_OFF_INTERVAL = 8'h08;
  localparam logic [7:0] CRS_OFF_XCVR     = 8'h0c;
  localparam logic [7:0] CRS_OFF_EXTCFG   = 8'h10;
  localparam logic [7:0] CRS_OFF_STATUS   = 8'h14;
  localparam logic [7:0] CRS_OFF_MASK     = 8'h18;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CRS_CTRL_MODE_LSB = 0;
  localparam int CRS_CTRL_START    = 3;
  localparam int CRS_CTRL_OPEN     = 4;
  localparam int CRS_CTRL_EXT      = 5;
  localparam int CRS_ID_DLC_LSB    = 29;
  localparam int CRS_ST_RXDATA     = 0;
  localparam int CRS_ST_REMSENT    = 1;
  localparam int CRS_ST_DATASENT   = 2;
  localparam int CRS_ST_WAKE       = 3;
  localparam int CRS_ST_OVERRUN    = 4;
  localparam int CRS_NUM_EVT       = 5;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] CRS_RST_INTERVAL = 32'h0000_9c40;
  localparam logic [31:0] CRS_RST_EXTCFG   = 32'h0000_0000;

  // ****************************************
  // Session mode and transceiver request codes
  // ****************************************
  localparam logic [2:0] CRS_MODE_IDLE     = 3'h0;
  localparam logic [2:0] CRS_MODE_CYCREMIN = 3'h1;
  localparam logic [2:0] CRS_MODE_EVTREMIN = 3'h2;
  localparam logic [2:0] CRS_MODE_CYCREMOUT = 3'h3;
  localparam logic [2:0] CRS_MODE_EVTREMOUT = 3'h4;
  localparam logic [2:0] CRS_MODE_STREAMIN = 3'h5;
  localparam logic [2:0] CRS_MODE_STREAMOUT = 3'h6;

  localparam logic [2:0] CRS_XREQ_NORMAL = 3'h1;
  localparam logic [2:0] CRS_XREQ_SLEEP  = 3'h2;
  localparam logic [2:0] CRS_XREQ_WAKE   = 3'h3;
  localparam logic [2:0] CRS_XREQ_FAST   = 3'h4;

  typedef enum logic [2:0] {
    XS_POWER_ON, XS_NORMAL, XS_SLEEP, XS_SOFT_WAKE, XS_SOFT_FAST
  } crs_xstate_t;

  typedef struct packed {
    logic [28:0] id;
    logic        rtr;
    logic [3:0]  dlc;
    logic [63:0] data;
  } crs_frame_t;

endpackage : crs_pkg

// File: src/crs_remote_sched.sv
// Purpose: Remote-frame scheduling, held-answer transmit and transceiver control
// Assumes: CAN controller logic on the same clock; wakeup pattern arrives from a pin
// Notes:   Host write and read calls are frame ports; configuration is on a plain port
//
// What this block does
// - Periodic remote input: remote frame at start, then one every interval, no writes.
// - Remote timer runs regardless of whether answering data frames arrive.
// - Remote input modes capture matching data frames for the next host read.
// - Remote output modes hold host-written data until a matching remote frame.
// - Matching remote frame sends pending data at once, never reaches host read.
// - Event remote input: host write is a trigger only, payload discarded.
// - Event remote input: a host write sets one pending remote frame; writes while one is pending merge.
// - Stream modes pass data and remote frames through unchanged, no timing.
// - Event remote output answers irregular remote requests like periodic output.
// - On-board or external transceiver selectable, external gets configured control.
// - Transceiver has five states; power-on on reset or session close; start to normal.
// - Normal request moves to normal from power-on, sleep, soft wake, soft fast.
// - Sleep request moves to sleep only from normal or soft wake.
// - Wakeup pattern in sleep returns to normal without a request.
// - Soft wake request works from power-on, normal or sleep.
// - Soft fast request works from power-on, normal, sleep or soft wake.
//
// The register addresses and the plain strobed port were chosen for this implementation.

`timescale 1ns/10ps

module crs_remote_sched
  import crs_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  output logic [31:0]      regRdData,
  // Host write call and read call
  input  wire logic        hostWrValid,
  input  wire crs_frame_t  hostWrFrame,
  output crs_frame_t       hostRdFrame,
  output logic             hostRdValid,
  input  wire logic        hostRdAck,
  // CAN controller side
  input  wire logic        rxValid,
  input  wire crs_frame_t  rxFrame,
  output logic             txValid,
  output crs_frame_t       txFrame,
  input  wire logic        txDone,
  // Transceiver pins and control
  input  wire logic        wakePin,
  output crs_xstate_t      xcvrState,
  output logic             xcvrExtSel,
  output logic [31:0]      xcvrExtCfg,
  // Interrupt
  output logic             irq
);

  // ****************************************
  // Reset release and pin synchroniser
  // ****************************************
  logic [1:0] rstSync_r;
  logic       rstN;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync_r <= 2'h0;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rstN = rstSync_r[1];

  // A change only counts once the second and third stages agree
  logic [2:0] wakeSync_r;
  logic       wakeLvl_r;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wakeSync_r <= 3'h0;
      wakeLvl_r  <= 1'b0;
    end else begin
      wakeSync_r <= {wakeSync_r[1:0], wakePin};
      if (wakeSync_r[1] == wakeSync_r[2]) begin
        wakeLvl_r <= wakeSync_r[2];
      end
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [31:0] ctrl_r;
  logic [31:0] idCfg_r;
  logic [31:0] interval_r;
  logic [31:0] extCfg_r;
  logic [CRS_NUM_EVT-1:0] status_r;
  logic [CRS_NUM_EVT-1:0] mask_r;
  logic [CRS_NUM_EVT-1:0] evt;
  logic        wrCtrl;
  logic        wrXcvr;

  assign wrCtrl = regWrEn && (regAddr == CRS_OFF_CTRL);
  assign wrXcvr = regWrEn && (regAddr == CRS_OFF_XCVR);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ctrl_r     <= 32'h0;
      idCfg_r    <= 32'h0;
      interval_r <= CRS_RST_INTERVAL;
      extCfg_r   <= CRS_RST_EXTCFG;
      mask_r     <= '0;
    end else if (regWrEn) begin
      case (regAddr)
        CRS_OFF_CTRL:     ctrl_r     <= regWrData;
        CRS_OFF_ID:       idCfg_r    <= regWrData;
        CRS_OFF_INTERVAL: interval_r <= regWrData;
        CRS_OFF_EXTCFG:   extCfg_r   <= regWrData;
        CRS_OFF_MASK:     mask_r     <= regWrData[CRS_NUM_EVT-1:0];
        default: ;
      endcase
    end
  end

  logic [2:0]  mode;
  logic        running;
  logic        running_r;
  logic        sessOpen_r;
  logic [28:0] cfgId;
  logic        remInMode;
  logic        remOutMode;
  logic        streamMode;

  assign mode       = ctrl_r[CRS_CTRL_MODE_LSB +: 3];
  assign running    = ctrl_r[CRS_CTRL_START] && ctrl_r[CRS_CTRL_OPEN];
  assign cfgId      = idCfg_r[28:0];
  assign remInMode  = (mode == CRS_MODE_CYCREMIN) || (mode == CRS_MODE_EVTREMIN);
  assign remOutMode = (mode == CRS_MODE_CYCREMOUT) || (mode == CRS_MODE_EVTREMOUT);
  assign streamMode = (mode == CRS_MODE_STREAMIN) || (mode == CRS_MODE_STREAMOUT);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      running_r  <= 1'b0;
      sessOpen_r <= 1'b0;
    end else begin
      running_r  <= running;
      sessOpen_r <= ctrl_r[CRS_CTRL_OPEN];
    end
  end

  function automatic logic idMatch(input crs_frame_t f, input logic [28:0] id);
    return f.id == id;
  endfunction : idMatch

  // ****************************************
  // Remote request scheduling
  // ****************************************
  logic [31:0] remTimer_r;
  logic        remPend_r;
  logic        remLaunch;
  logic        dataLaunch;
  logic        dataPend_r;
  logic        cycTick;
  logic        startEdge;

  assign startEdge = running && !running_r;
  assign cycTick   = (mode == CRS_MODE_CYCREMIN) && running && (remTimer_r == 32'h2);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      remTimer_r <= 32'h0;
    end else if (!running || mode != CRS_MODE_CYCREMIN) begin
      remTimer_r <= 32'h0;
    end else if (remLaunch) begin
      // Tick fires at two since the pending stage adds a cycle; below two acts as two
      remTimer_r <= (interval_r < 32'h2) ? 32'h2 : interval_r;
    end else if (remTimer_r != 32'h0) begin
      remTimer_r <= remTimer_r - 32'h1;
    end
  end

  // First request at start, then per tick
  // A write only triggers; writes while pending merge
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      remPend_r <= 1'b0;
    end else if ((mode == CRS_MODE_CYCREMIN && (startEdge || cycTick)) ||
                 (mode == CRS_MODE_EVTREMIN && running && hostWrValid)) begin
      remPend_r <= 1'b1;
    end else if (remLaunch || !running) begin
      remPend_r <= 1'b0;
    end
  end

  // ****************************************
  // Held answer and stream write path
  // ****************************************
  crs_frame_t holdFrame_r;
  logic       holdValid_r;
  logic       remMatch;

  // Matching request picked off the receive path
  assign remMatch = remOutMode && running && rxValid && rxFrame.rtr && idMatch(rxFrame, cfgId);

  // Store only; remote out payload waits here
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      holdFrame_r <= '0;
      holdValid_r <= 1'b0;
    end else if (!ctrl_r[CRS_CTRL_OPEN]) begin
      holdValid_r <= 1'b0;
    end else if (hostWrValid && (remOutMode || mode == CRS_MODE_STREAMOUT)) begin
      holdFrame_r <= hostWrFrame;
      if (remOutMode) begin
        holdFrame_r.id  <= cfgId;
        holdFrame_r.rtr <= 1'b0;
      end
      holdValid_r <= 1'b1;
    end else if (dataLaunch && mode == CRS_MODE_STREAMOUT) begin
      holdValid_r <= 1'b0;
    end
  end

  // Send at once; stream writes go straight out
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      dataPend_r <= 1'b0;
    end else if ((remMatch && holdValid_r) ||
                 (mode == CRS_MODE_STREAMOUT && running && hostWrValid)) begin
      dataPend_r <= 1'b1;
    end else if (dataLaunch || !running) begin
      dataPend_r <= 1'b0;
    end
  end

  // ****************************************
  // Transmit slot
  // ****************************************
  assign remLaunch  = !txValid && remPend_r && !dataPend_r;
  assign dataLaunch = !txValid && dataPend_r;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      txValid <= 1'b0;
      txFrame <= '0;
    end else if (dataLaunch) begin
      txValid <= 1'b1;
      txFrame <= holdFrame_r;
    end else if (remLaunch) begin
      txValid      <= 1'b1;
      txFrame.id   <= cfgId;
      txFrame.rtr  <= 1'b1;
      txFrame.dlc  <= idCfg_r[CRS_ID_DLC_LSB +: 3] == 3'h0 ? 4'h0 : {1'b0, idCfg_r[31:29]};
      txFrame.data <= 64'h0;
    end else if (txDone) begin
      txValid <= 1'b0;
    end
  end

  // ****************************************
  // Host read path
  // ****************************************
  logic rxTake;

  // Matching data in remote input; everything in stream input
  assign rxTake = running && rxValid &&
                  ((remInMode && !rxFrame.rtr && idMatch(rxFrame, cfgId)) ||
                   mode == CRS_MODE_STREAMIN);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      hostRdFrame <= '0;
      hostRdValid <= 1'b0;
    end else if (rxTake) begin
      hostRdFrame <= rxFrame;
      hostRdValid <= 1'b1;
    end else if (hostRdAck) begin
      hostRdValid <= 1'b0;
    end
  end

  // ****************************************
  // Transceiver state machine
  // ****************************************
  logic wakeLvlD_r;
  logic wakeRise;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wakeLvlD_r <= 1'b0;
    end else begin
      wakeLvlD_r <= wakeLvl_r;
    end
  end
  assign wakeRise = wakeLvl_r && !wakeLvlD_r;

  logic [2:0] xReq;
  assign xReq = regWrData[2:0];

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      xcvrState <= XS_POWER_ON;
    end else if (sessOpen_r && !ctrl_r[CRS_CTRL_OPEN]) begin
      xcvrState <= XS_POWER_ON;
    end else if (wrXcvr && xReq == CRS_XREQ_FAST) begin
      xcvrState <= XS_SOFT_FAST;
    end else if (wrXcvr && xReq == CRS_XREQ_NORMAL) begin
      xcvrState <= XS_NORMAL;
    end else begin
      case (xcvrState)
        XS_POWER_ON: begin
          if (startEdge) begin
            xcvrState <= XS_NORMAL;
          end else if (wrXcvr && xReq == CRS_XREQ_WAKE) begin
            xcvrState <= XS_SOFT_WAKE;
          end
        end
        XS_NORMAL: begin
          if (wrXcvr && xReq == CRS_XREQ_SLEEP) begin
            xcvrState <= XS_SLEEP;
          end else if (wrXcvr && xReq == CRS_XREQ_WAKE) begin
            xcvrState <= XS_SOFT_WAKE;
          end
        end
        XS_SLEEP: begin
          if (wakeRise) begin
            xcvrState <= XS_NORMAL;
          end else if (wrXcvr && xReq == CRS_XREQ_WAKE) begin
            xcvrState <= XS_SOFT_WAKE;
          end
        end
        XS_SOFT_WAKE: begin
          if (wrXcvr && xReq == CRS_XREQ_SLEEP) begin
            xcvrState <= XS_SLEEP;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      xcvrExtSel <= 1'b0;
      xcvrExtCfg <= 32'h0;
    end else begin
      xcvrExtSel <= ctrl_r[CRS_CTRL_EXT];
      xcvrExtCfg <= ctrl_r[CRS_CTRL_EXT] ? extCfg_r : 32'h0;
    end
  end

  // ****************************************
  // Interrupt status and register reads
  // ****************************************
  always_comb begin
    evt = '0;
    evt[CRS_ST_RXDATA]   = rxTake;
    evt[CRS_ST_REMSENT]  = txDone && txFrame.rtr;
    evt[CRS_ST_DATASENT] = txDone && !txFrame.rtr;
    evt[CRS_ST_WAKE]     = wakeRise && xcvrState == XS_SLEEP;
    evt[CRS_ST_OVERRUN]  = rxTake && hostRdValid && !hostRdAck;
  end

  // Set beats a same-cycle write-one clear
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      status_r <= '0;
    end else if (regWrEn && regAddr == CRS_OFF_STATUS) begin
      status_r <= (status_r & ~regWrData[CRS_NUM_EVT-1:0]) | evt;
    end else begin
      status_r <= status_r | evt;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_r & mask_r);
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      regRdData <= 32'h0;
    end else if (regRdEn) begin
      case (regAddr)
        CRS_OFF_CTRL:     regRdData <= ctrl_r;
        CRS_OFF_ID:       regRdData <= idCfg_r;
        CRS_OFF_INTERVAL: regRdData <= interval_r;
        CRS_OFF_XCVR:     regRdData <= {29'h0, xcvrState};
        CRS_OFF_EXTCFG:   regRdData <= extCfg_r;
        CRS_OFF_STATUS:   regRdData <= {27'h0, status_r};
        CRS_OFF_MASK:     regRdData <= {27'h0, mask_r};
        default:          regRdData <= 32'h0;
      endcase
    end else begin
      regRdData <= 32'h0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence remOut_s;
    txValid && txFrame.rtr && txFrame.id == $past(cfgId);
  endsequence

  chk_first_remote: assert property (@(posedge clk) disable iff (!rstN)
    (startEdge && mode == CRS_MODE_CYCREMIN && !txValid) |=> remPend_r ##1 remOut_s)
    else $error("periodic remote not sent at start");

  chk_timer_reload: assert property (@(posedge clk) disable iff (!rstN)
    (remLaunch && running && mode == CRS_MODE_CYCREMIN && interval_r > 32'h1 && !wrCtrl)
    |=> remTimer_r == $past(interval_r))
    else $error("remote timer not reloaded");

  chk_timer_free: assert property (@(posedge clk) disable iff (!rstN)
    (cycTick && !startEdge) |=> remPend_r)
    else $error("remote request lost on timer expiry");

  chk_rx_capture: assert property (@(posedge clk) disable iff (!rstN)
    rxTake |=> hostRdValid && hostRdFrame == $past(rxFrame))
    else $error("received data not captured");

  chk_hold_data: assert property (@(posedge clk) disable iff (!rstN)
    (dataLaunch && remOutMode) |-> $past(remMatch, 1) || $past(dataPend_r, 1))
    else $error("held data sent without request");

  chk_remote_hidden: assert property (@(posedge clk) disable iff (!rstN)
    (remMatch && !hostRdValid) |=> !hostRdValid)
    else $error("remote frame reached host read path");

  chk_event_once: assert property (@(posedge clk) disable iff (!rstN)
    (hostWrValid && running && mode == CRS_MODE_EVTREMIN && !wrCtrl) |=> remPend_r)
    else $error("write did not trigger remote");

  chk_sleep_guard: assert property (@(posedge clk) disable iff (!rstN)
    (wrXcvr && xReq == CRS_XREQ_SLEEP && xcvrState == XS_POWER_ON && !startEdge &&
     !(sessOpen_r && !ctrl_r[CRS_CTRL_OPEN])) |=> xcvrState == XS_POWER_ON)
    else $error("illegal sleep transition taken");

  chk_wake_normal: assert property (@(posedge clk) disable iff (!rstN)
    (xcvrState == XS_SLEEP && wakeRise && !wrXcvr &&
     !(sessOpen_r && !ctrl_r[CRS_CTRL_OPEN])) |=> xcvrState == XS_NORMAL)
    else $error("wakeup pattern ignored in sleep");

endmodule : crs_remote_sched

// File: verif/crs_far_node.sv
// Purpose: Far-side CAN node for the remote-frame scheduler bench
// Assumes: Same clock as the block; lag sets the transmit acknowledge delay
// Notes:   Idle receive lines toggle so a stale frame never looks current
`timescale 1ns/10ps

module crs_far_node
  import crs_pkg::*;
(
  // Clock and bench control
  input  wire logic       clk,
  input  wire logic [3:0] lag,
  input  wire logic       answer,
  input  wire logic       reqValid,
  input  wire crs_frame_t reqFrame,
  // Block side
  input  wire logic       txValid,
  input  wire crs_frame_t txFrame,
  output logic            txDone = 1'b0,
  output logic            rxValid = 1'b0,
  output crs_frame_t      rxFrame = '0
);
  logic [3:0] waitCnt = 4'h0;
  logic [1:0] replyDue = 2'h0;
  crs_frame_t reply;
  logic       finish;

  // Each output is assigned once per edge
  assign finish = txValid && !txDone && (waitCnt == lag);

  always @(posedge clk) begin
    txDone  <= finish;
    rxValid <= reqValid || (replyDue == 2'h1);
    rxFrame <= reqValid ? reqFrame : ((replyDue == 2'h1) ? reply : ~rxFrame);
    if (txValid && !txDone) begin
      waitCnt <= finish ? 4'h0 : waitCnt + 4'h1;
    end
    if (finish && txFrame.rtr && answer) begin
      replyDue <= 2'h2;
      reply    <= '{txFrame.id, 1'b0, 4'h8, {2{3'h0, txFrame.id}}};
    end else if (replyDue != 2'h0) begin
      replyDue <= replyDue - 2'h1;
    end
  end
endmodule : crs_far_node

// File: verif/crs_remote_sched_test.sv
// Purpose: Self-checking bench for the remote-frame scheduler
// Assumes: Far node model on the same clock
// Notes:   Expected frames queue up and are matched as outputs appear
`timescale 1ns/10ps

module crs_remote_sched_test
  import crs_pkg::*;
;
  logic        clk;
  logic        reset_n = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic        regWrEn = 1'b0;
  logic        regRdEn = 1'b0;
  logic        hostWrValid = 1'b0;
  crs_frame_t  hostWrFrame = '0;
  logic        hostRdAck = 1'b0;
  logic        wakePin = 1'b0;
  logic        reqValid = 1'b0;
  logic        answer = 1'b1;
  logic        txPrev = 1'b0;
  logic [3:0]  lag = 4'h0;
  crs_frame_t  reqFrame = '0;
  logic [31:0] regRdData, xcvrExtCfg, d, v;
  logic        hostRdValid, rxValid, txValid, txDone, xcvrExtSel, irq;
  crs_frame_t  hostRdFrame, rxFrame, txFrame, seenTx, f;
  crs_xstate_t xcvrState;
  logic [28:0] cfgId;
  logic [15:0] seed = 16'h164f;
  int          n;
  int          n_mismatch = 0;
  int          tests_run = 0;
  crs_frame_t  expTx[$];
  crs_frame_t  expRd[$];
  logic [2:0]  outM [2] = '{CRS_MODE_CYCREMOUT, CRS_MODE_EVTREMOUT};
  // Transceiver requests, 0 meaning a wakeup pattern on the pin
  logic [2:0]  xReq [13] = '{3'h2, 3'h4, 3'h2, 3'h3, 3'h1, 3'h2, 3'h0, 3'h3, 3'h2,
    3'h4, 3'h1, 3'h3, 3'h4};
  crs_xstate_t xExp [13] = '{XS_POWER_ON, XS_SOFT_FAST, XS_SOFT_FAST, XS_SOFT_FAST,
    XS_NORMAL, XS_SLEEP, XS_NORMAL, XS_SOFT_WAKE, XS_SLEEP, XS_SOFT_FAST, XS_NORMAL,
    XS_SOFT_WAKE, XS_SOFT_FAST};

  crs_remote_sched u_dut (.clk, .reset_n, .regAddr, .regWrData, .regWrEn, .regRdEn,
    .regRdData, .hostWrValid, .hostWrFrame, .hostRdFrame, .hostRdValid, .hostRdAck,
    .rxValid, .rxFrame, .txValid, .txFrame, .txDone, .wakePin, .xcvrState,
    .xcvrExtSel, .xcvrExtCfg, .irq);
  crs_far_node u_far (.clk, .lag, .answer, .reqValid, .reqFrame, .txValid, .txFrame,
    .txDone, .rxValid, .rxFrame);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    logic [31:0] r;
    for (int i = 0; i < 32; i++) begin
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      r[i] = seed[0];
    end
    return r;
  endfunction : rnd

  function automatic crs_frame_t remOf(input logic [28:0] i);
    return '{i, 1'b1, 4'h2, 64'h0};
  endfunction : remOf

  task automatic check(input logic [97:0] seen, input logic [97:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge clk);
    regAddr <= a;
    regWrData <= dat;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] dat);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1 dat = regRdData;
  endtask : rd

  task automatic hw(input crs_frame_t fr);
    @(posedge clk);
    hostWrValid <= 1'b1;
    hostWrFrame <= fr;
    @(posedge clk);
    hostWrValid <= 1'b0;
  endtask : hw

  task automatic req(input crs_frame_t fr);
    @(posedge clk);
    reqValid <= 1'b1;
    reqFrame <= fr;
    @(posedge clk);
    reqValid <= 1'b0;
  endtask : req

  // Cycles until the next launch, 300 if none comes
  task automatic nextRise(output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      #1 cnt++;
    end while (!(txValid && !txPrev) && cnt < 300);
  endtask : nextRise

  // ****************************************
  // Result monitors
  // ****************************************
  always @(posedge clk) begin
    txPrev <= txValid;
    hostRdAck <= hostRdValid && !hostRdAck;
    if (txValid && txDone) begin
      seenTx = txFrame;
      if (expTx.size() == 0) check(98'h1, 98'h0);
      else check(seenTx, expTx.pop_front());
    end
    if (hostRdValid && !hostRdAck) begin
      if (expRd.size() == 0) check(98'h1, 98'h0);
      else check(hostRdFrame, expRd.pop_front());
    end
  end

  initial begin
    #250000;
    n_mismatch++;
    final_report();
  end

  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(CRS_OFF_INTERVAL, d);
    check(98'(d), 98'(CRS_RST_INTERVAL));
    rd(8'h1c, d);
    check(98'(d), 98'h0);
    cfgId = 29'(rnd());
    wr(CRS_OFF_ID, {3'h2, cfgId});
    wr(CRS_OFF_INTERVAL, 32'h8);
    repeat (4) expTx.push_back(remOf(cfgId));
    repeat (2) expRd.push_back('{cfgId, 1'b0, 4'h8, {2{3'h0, cfgId}}});
    wr(CRS_OFF_CTRL, 32'h18 | 32'(CRS_MODE_CYCREMIN));
    nextRise(n);
    check(98'(xcvrState), 98'(XS_NORMAL));
    nextRise(n);
    check(98'(n), 98'h8);
    @(posedge clk);
    answer <= 1'b0;
    nextRise(n);
    check(98'(n + 1), 98'h8);
    nextRise(n);
    check(98'(n), 98'h8);
    wr(CRS_OFF_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    #1 check(98'(xcvrState), 98'(XS_POWER_ON));
    lag <= 4'h3;
    wr(CRS_OFF_CTRL, 32'h18 | 32'(CRS_MODE_EVTREMIN));
    expTx.push_back(remOf(cfgId));
    hw('{29'(rnd()), 1'b0, 4'h8, {rnd(), rnd()}});
    nextRise(n);
    check(98'(n > 3), 98'h0);
    nextRise(n);
    check(98'(n), 98'h12c);
    for (int k = 0; k < 2; k++) begin
      wr(CRS_OFF_CTRL, 32'h18 | 32'(outM[k]));
      f = '{29'(rnd()), 1'b0, 4'h8, {rnd(), rnd()}};
      hw(f);
      repeat (12) @(posedge clk);
      #1 check(98'(txValid), 98'h0);
      f.id = cfgId;
      repeat (2) begin
        expTx.push_back(f);
        req(remOf(cfgId));
        nextRise(n);
        check(98'(n > 3), 98'h0);
        repeat (8) @(posedge clk);
      end
    end
    wr(CRS_OFF_CTRL, 32'h18 | 32'(CRS_MODE_STREAMIN));
    for (int k = 0; k < 2; k++) begin
      f = '{29'(rnd()), k[0], 4'h8, {rnd(), rnd()}};
      expRd.push_back(f);
      req(f);
      repeat (6) @(posedge clk);
    end
    wr(CRS_OFF_CTRL, 32'h18 | 32'(CRS_MODE_STREAMOUT));
    for (int k = 0; k < 2; k++) begin
      f = '{29'(rnd()), k[0], 4'h8, k[0] ? 64'h0 : {rnd(), rnd()}};
      expTx.push_back(f);
      hw(f);
      repeat (10) @(posedge clk);
    end
    v = rnd();
    wr(CRS_OFF_EXTCFG, v);
    wr(CRS_OFF_CTRL, 32'h20);
    repeat (4) @(posedge clk);
    #1 check(98'({xcvrExtSel, xcvrExtCfg}), {65'h0, 1'b1, v});
    for (int i = 0; i < 13; i++) begin
      if (xReq[i] == 3'h0) begin
        @(posedge clk);
        wakePin <= 1'b1;
        repeat (8) @(posedge clk);
        wakePin <= 1'b0;
      end else begin
        wr(CRS_OFF_XCVR, {29'h0, xReq[i]});
      end
      repeat (2) @(posedge clk);
      #1 check(98'(xcvrState), 98'(xExp[i]));
    end
    rd(CRS_OFF_STATUS, d);
    check(98'(d), 98'hf);
    check(98'(irq), 98'h0);
    wr(CRS_OFF_MASK, 32'h8);
    repeat (3) @(posedge clk);
    #1 check(98'(irq), 98'h1);
    wr(CRS_OFF_STATUS, 32'h8);
    repeat (3) @(posedge clk);
    #1 check(98'(irq), 98'h0);
    rd(CRS_OFF_STATUS, d);
    check(98'(d), 98'h7);
    check(98'(expTx.size() + expRd.size()), 98'h0);
    final_report();
  end
endmodule : crs_remote_sched_test
